// File: src/rtc_wakeup_timer.sv
// Wakeup timer core: source selection, 24-bit counter and interrupt pins.
`timescale 1ns/100ps
`default_nettype none
module rtc_wakeup_timer
    import wakeup_timer_pkg::*;
#(
    parameter int WIDTH = COUNT_WIDTH,
    parameter int BASE_CYCLES = int'(TICK_1024HZ_CYCLES),
    parameter int SHORT_CYCLES = int'(RELEASE_SHORT_CYCLES),
    parameter int LONG_CYCLES = int'(RELEASE_LONG_CYCLES)
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [1:0] sourceSelectField,
    input wire logic externalSourceSelect,
    input wire logic countDirection,
    input wire logic [7:0] presetCountLow,
    input wire logic [7:0] presetCountMid,
    input wire logic [7:0] presetCountHigh,
    input wire logic timerRun,
    input wire logic modeGateEnable,
    input wire logic modeGateSelect,
    input wire logic safeMode,
    input wire logic suspendCount,
    input wire logic autoReturnDisable,
    input wire logic timerIrqEnable,
    input wire logic irqToFreqOut,
    input wire logic flagClear,
    input wire logic extEventPin,
    output logic timerEventFlag,
    output logic [WIDTH-1:0] countValue,
    output logic intPinOut,
    output logic intPinOe,
    output logic freqOutPin
);

    logic tick1024;
    logic tick64;
    logic tick1;
    logic tick60s;
    logic [2:0] extSync_q;
    logic extLevel_q;
    logic extRise;
    logic srcTick;
    logic [WIDTH-1:0] preset;
    logic [WIDTH-1:0] count_q;
    logic running_q;
    logic gateOpen;
    logic countEnable;
    logic timerEvent;
    logic flag_q;
    logic pinLow;
    pin_state_e pinState_q;
    logic [31:0] releaseCount_q;
    logic [31:0] releaseLimit;
    logic freqOut_q;

    rate_divider #(
        .BASE_CYCLES(BASE_CYCLES)
    ) u_rate_divider (
        .clock(clock),
        .rst_n(rst_n),
        .tick1024(tick1024),
        .tick64(tick64),
        .tick1(tick1),
        .tick60s(tick60s)
    );

    // ----------------------------------------------------------------
    // External event pin
    // ----------------------------------------------------------------
    // Synchronised rising edge only: two-sample agreement filter, no edge choice on this path
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            extSync_q <= 3'h0;
            extLevel_q <= 1'b0;
        end else begin
            extSync_q <= {extSync_q[1:0], extEventPin};
            if (extSync_q[1] == extSync_q[2]) begin
                extLevel_q <= extSync_q[2];
            end
        end
    end

    assign extRise = (extSync_q[1] == extSync_q[2]) && extSync_q[2] && !extLevel_q;

    // ----------------------------------------------------------------
    // Source select
    // ----------------------------------------------------------------
    always_comb begin
        srcTick = 1'b0;
        if (externalSourceSelect) begin
            srcTick = extRise;
        end else begin
            case (sourceSelectField)
                SRC_1024HZ: srcTick = tick1024;
                SRC_64HZ: srcTick = tick64;
                SRC_1HZ: srcTick = tick1;
                SRC_60S: srcTick = tick60s;
                default: srcTick = 1'b0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------
    assign preset = WIDTH'({presetCountHigh, presetCountMid, presetCountLow});
    assign gateOpen = !modeGateEnable || (modeGateSelect == safeMode);
    assign countEnable = running_q && srcTick && gateOpen && !suspendCount
                         && (preset != WIDTH'(COUNT_ZERO));
    assign timerEvent = countEnable && (countDirection ? (count_q >= preset)
                                                        : (count_q == WIDTH'(COUNT_ONE)));

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            running_q <= 1'b0;
            count_q <= '0;
        end else if (!timerRun) begin
            running_q <= 1'b0;
            count_q <= count_q;
        end else if (!running_q) begin
            running_q <= 1'b1;
            count_q <= countDirection ? WIDTH'(COUNT_ONE) : preset;
        end else if (countEnable) begin
            if (countDirection) begin
                count_q <= timerEvent ? WIDTH'(COUNT_ONE) : count_q + WIDTH'(COUNT_ONE);
            end else begin
                count_q <= timerEvent ? preset : count_q - WIDTH'(COUNT_ONE);
            end
        end
    end

    // Preset shows while idle, live count while running
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            countValue <= '0;
        end else begin
            countValue <= running_q ? count_q : preset;
        end
    end

    // ----------------------------------------------------------------
    // Event flag
    // ----------------------------------------------------------------
    // A new event beats a simultaneous clear
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            flag_q <= 1'b0;
        end else if (timerEvent) begin
            flag_q <= 1'b1;
        end else if (flagClear) begin
            flag_q <= 1'b0;
        end
    end

    assign timerEventFlag = flag_q;

    // ----------------------------------------------------------------
    // Interrupt pin timing
    // ----------------------------------------------------------------
    always_comb begin
        releaseLimit = 32'(LONG_CYCLES);
        if (sourceSelectField == SRC_1024HZ) begin
            releaseLimit = 32'(SHORT_CYCLES);
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pinState_q <= PIN_IDLE;
            releaseCount_q <= '0;
        end else if (!timerIrqEnable || !timerRun || (flagClear && !timerEvent)) begin
            pinState_q <= PIN_IDLE;
            releaseCount_q <= '0;
        end else begin
            case (pinState_q)
                PIN_IDLE: begin
                    if (timerEvent) begin
                        releaseCount_q <= '0;
                        pinState_q <= (autoReturnDisable || externalSourceSelect)
                                      ? PIN_HELD : PIN_TIMED;
                    end
                end
                PIN_TIMED: begin
                    if (timerEvent) begin
                        releaseCount_q <= '0;
                    end else if (releaseCount_q >= releaseLimit - 32'h1) begin
                        pinState_q <= PIN_IDLE;
                    end else begin
                        releaseCount_q <= releaseCount_q + 32'h1;
                    end
                end
                PIN_HELD: pinState_q <= PIN_HELD;
                default: pinState_q <= PIN_IDLE;
            endcase
        end
    end

    assign pinLow = (pinState_q != PIN_IDLE);

    // ----------------------------------------------------------------
    // Output routing
    // ----------------------------------------------------------------
    // Open-drain: drive only the low level
    assign intPinOut = 1'b0;
    assign intPinOe = pinLow && !irqToFreqOut;

    // Active-low request, idles high when routed away
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            freqOut_q <= 1'b1;
        end else begin
            freqOut_q <= !(pinLow && irqToFreqOut);
        end
    end

    assign freqOutPin = freqOut_q;

endmodule
`default_nettype wire

// File: src/wakeup_timer_pkg.sv
// Constants and types shared by the wakeup timer design.
//
// Notes on behaviour
// - Counter is 24 bits, counts up or down
// - Source select chooses divided clock or pin
// - Pin auto-release 488us or 7.812ms, none external
// - External source bypasses filter and edge select; code keeps a two-sample agreement filter
// - Direction bit one means count up
// - Event when up passes preset, down hits zero
// - Preset is the count limit
// - Zero preset: no counting, no event
// - Mode gate limits counting to one mode
// - Gated counter holds value, then resumes
// - Interrupt may route to frequency output pin
// - Start loads 1 up, preset down; reload
// - Event sets flag; enabled flag drives pin low
// - Auto-return disable keeps pin low
// - Suspend freezes counter, resume continues
package wakeup_timer_pkg;

    // ----------------------------------------------------------------
    // Widths and encodings
    // ----------------------------------------------------------------
    localparam int COUNT_WIDTH = 24;
    localparam logic [1:0] SRC_1024HZ = 2'h0;
    localparam logic [1:0] SRC_64HZ = 2'h1;
    localparam logic [1:0] SRC_1HZ = 2'h2;
    localparam logic [1:0] SRC_60S = 2'h3;
    localparam logic [COUNT_WIDTH-1:0] COUNT_ZERO = 24'h000000;
    localparam logic [COUNT_WIDTH-1:0] COUNT_ONE = 24'h000001;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam longint CLOCK_HZ = 200000000;
    localparam longint CLOCK_PERIOD_PS = 5000;
    localparam longint RELEASE_SHORT_NS = 488000;
    localparam longint RELEASE_LONG_NS = 7812000;
    localparam longint RELEASE_SHORT_CYCLES = (RELEASE_SHORT_NS * 1000) / CLOCK_PERIOD_PS;
    localparam longint RELEASE_LONG_CYCLES = (RELEASE_LONG_NS * 1000) / CLOCK_PERIOD_PS;
    localparam longint TICK_1024HZ_CYCLES = CLOCK_HZ / 1024;
    localparam int TICKS_PER_64HZ = 16;
    localparam int TICKS_PER_1HZ = 64;
    localparam int TICKS_PER_60S = 60;

    typedef enum logic [1:0] {
        PIN_IDLE = 2'b00,
        PIN_TIMED = 2'b01,
        PIN_HELD = 2'b10
    } pin_state_e;

endpackage

// File: src/rate_divider.sv
// Divider chain producing one-cycle enable pulses for the source rates.
`timescale 1ns/100ps
`default_nettype none
module rate_divider
    import wakeup_timer_pkg::*;
#(
    parameter int BASE_CYCLES = int'(TICK_1024HZ_CYCLES)
) (
    input wire logic clock,
    input wire logic rst_n,
    output logic tick1024,
    output logic tick64,
    output logic tick1,
    output logic tick60s
);

    logic [31:0] baseCount_q;
    logic [3:0] div16_q;
    logic [5:0] div64_q;
    logic [5:0] div60_q;

    // ----------------------------------------------------------------
    // Base prescaler
    // ----------------------------------------------------------------
    // Free running, so the first tick after a start may come early
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            baseCount_q <= '0;
        end else if (baseCount_q == 32'(BASE_CYCLES - 1)) begin
            baseCount_q <= '0;
        end else begin
            baseCount_q <= baseCount_q + 32'h1;
        end
    end

    assign tick1024 = (baseCount_q == 32'(BASE_CYCLES - 1));
    assign tick64 = tick1024 && (div16_q == 4'(TICKS_PER_64HZ - 1));
    assign tick1 = tick64 && (div64_q == 6'(TICKS_PER_1HZ - 1));
    assign tick60s = tick1 && (div60_q == 6'(TICKS_PER_60S - 1));

    // ----------------------------------------------------------------
    // Cascaded stages
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            div16_q <= '0;
            div64_q <= '0;
            div60_q <= '0;
        end else begin
            if (tick1024) begin
                div16_q <= tick64 ? 4'h0 : div16_q + 4'h1;
            end
            if (tick64) begin
                div64_q <= tick1 ? 6'h00 : div64_q + 6'h01;
            end
            if (tick1) begin
                div60_q <= tick60s ? 6'h00 : div60_q + 6'h01;
            end
        end
    end

endmodule
`default_nettype wire

// File: tb/ext_event_source.sv
// Behavioural source of external count events.
`timescale 1ns/100ps
`default_nettype none
module ext_event_source (
    input wire logic clock,
    input wire logic burst,
    output logic extEventPin
);
    // ------------------------------------------------------------
    // Pulse train, idles low as if pulled down
    // ------------------------------------------------------------
    logic [3:0] phase_q = 4'h0;
    // Eight cycles high, eight low: slow enough for the synchroniser
    always_ff @(posedge clock) begin
        phase_q <= burst ? phase_q + 4'h1 : 4'h0;
    end
    assign extEventPin = phase_q[3];
endmodule
`default_nettype wire

// File: tb/wakeup_timer_asserts.sv
// Port checker for the wakeup timer core.
`timescale 1ns/100ps
`default_nettype none
module wakeup_timer_asserts
    import wakeup_timer_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic countDirection,
    input wire logic [7:0] presetCountLow,
    input wire logic [7:0] presetCountMid,
    input wire logic [7:0] presetCountHigh,
    input wire logic timerRun,
    input wire logic suspendCount,
    input wire logic timerIrqEnable,
    input wire logic flagClear,
    input wire logic timerEventFlag,
    input wire logic [COUNT_WIDTH-1:0] countValue,
    input wire logic intPinOut,
    input wire logic intPinOe,
    input wire logic freqOutPin
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    logic [COUNT_WIDTH-1:0] preset;
    assign preset = {presetCountHigh, presetCountMid, presetCountLow};
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    property p_reset;
        $rose(rst_n) |-> !timerEventFlag && !intPinOe && freqOutPin;
    endproperty
    a_reset: assert property (p_reset)
        else $error("outputs not cleared by reset");
    property p_drain;
        intPinOut == 1'b0;
    endproperty
    a_drain: assert property (p_drain)
        else $error("interrupt pin driven high");
    property p_up_load;
        $rose(timerRun) && countDirection && preset != COUNT_ZERO |-> ##[1:2] countValue == COUNT_ONE;
    endproperty
    a_up_load: assert property (p_up_load)
        else $error("up count did not load one");
    property p_down_load;
        $rose(timerRun) && !countDirection |-> ##[1:2] countValue == preset;
    endproperty
    a_down_load: assert property (p_down_load)
        else $error("down count did not load preset");
    property p_zero;
        preset == COUNT_ZERO && $stable(preset) |-> !$rose(timerEventFlag);
    endproperty
    a_zero: assert property (p_zero)
        else $error("event with zero preset");
    property p_enable;
        (!timerIrqEnable)[*2] |-> !intPinOe;
    endproperty
    a_enable: assert property (p_enable)
        else $error("pin low while disabled");
    property p_sticky;
        timerEventFlag && !flagClear |=> timerEventFlag;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("flag dropped without clear");
    property p_suspend;
        (timerRun && suspendCount)[*2] |=> $stable(countValue);
    endproperty
    a_suspend: assert property (p_suspend)
        else $error("count moved while suspended");
endmodule
bind rtc_wakeup_timer wakeup_timer_asserts wakeup_timer_asserts_i (
    .clock(clock), .rst_n(rst_n), .countDirection(countDirection),
    .presetCountLow(presetCountLow), .presetCountMid(presetCountMid),
    .presetCountHigh(presetCountHigh), .timerRun(timerRun), .suspendCount(suspendCount),
    .timerIrqEnable(timerIrqEnable), .flagClear(flagClear), .timerEventFlag(timerEventFlag),
    .countValue(countValue), .intPinOut(intPinOut), .intPinOe(intPinOe),
    .freqOutPin(freqOutPin)
);
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the wakeup timer core.
`timescale 1ns/100ps
`default_nettype none
module tb;
    import wakeup_timer_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] src = 2'h0;
    logic ext = 1'b0, dir = 1'b1, run = 1'b0, gateEn = 1'b0, gateSel = 1'b0, safe = 1'b0;
    logic susp = 1'b0, ard = 1'b0, ie = 1'b1, toFout = 1'b0, clr = 1'b0, burst = 1'b0;
    logic [23:0] pre = 24'h000003;
    logic flag, oe, pinOut, freq_out_pin, extPin;
    logic [23:0] cnt;
    int fails = 0, checksDone = 0, n;
    int per[3] = '{4, 64, 4096};
    always #2.5 clock = ~clock;
    rtc_wakeup_timer #(.BASE_CYCLES(4), .SHORT_CYCLES(8), .LONG_CYCLES(16)) rtc_wakeup_timer_i (
        .clock(clock), .rst_n(rst_n), .sourceSelectField(src), .externalSourceSelect(ext),
        .countDirection(dir), .presetCountLow(pre[7:0]), .presetCountMid(pre[15:8]),
        .presetCountHigh(pre[23:16]), .timerRun(run), .modeGateEnable(gateEn),
        .modeGateSelect(gateSel), .safeMode(safe), .suspendCount(susp),
        .autoReturnDisable(ard), .timerIrqEnable(ie), .irqToFreqOut(toFout),
        .flagClear(clr), .extEventPin(extPin), .timerEventFlag(flag), .countValue(cnt),
        .intPinOut(pinOut), .intPinOe(oe), .freqOutPin(freq_out_pin));
    ext_event_source ext_event_source_i (.clock(clock), .burst(burst), .extEventPin(extPin));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        checksDone++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(negedge clock);
    endtask
    task automatic waitFlag(output int c);
        c = 0;
        while (flag !== 1'b1 && c < 20000) begin
            tick(1);
            c++;
        end
        // A missing event counts as a mismatch
        chk(24'(flag), 24'h000001);
    endtask
    task automatic clear();
        clr = 1'b1;
        tick(1);
        clr = 1'b0;
        tick(1);
    endtask
    // Preset only touched while stopped
    task automatic start(input logic [1:0] s, input logic e, input logic d, input logic [23:0] p);
        run = 1'b0;
        tick(2);
        src = s;
        ext = e;
        dir = d;
        pre = p;
        tick(2);
        clear();
        run = 1'b1;
    endtask
    task automatic summarize();
        if (fails == 0 && checksDone > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        tick(12);
        rst_n = 1'b1;
        tick(1);
        chk({pinOut, oe, flag, freq_out_pin}, 24'h000001);
        for (int s = 0; s < 3; s++) begin
            start(s[1:0], 1'b0, s != 1, 24'h000003);
            waitFlag(n);
            // Count output lags the counter by one cycle
            tick(1);
            chk(cnt, (s != 1) ? 24'h000001 : 24'h000003);
            clear();
            waitFlag(n);
            chk(n + 3, 3 * per[s]);
            tick((s == 0) ? 5 : 13);
            chk({flag, oe}, 24'h000003);
            tick(5);
            chk(oe, 1'b0);
        end
        start(2'h3, 1'b0, 1'b1, 24'h000001);
        tick(300);
        chk(flag, 1'b0);
        start(2'h0, 1'b0, 1'b1, 24'h000000);
        tick(100);
        chk({flag, oe}, 24'h000000);
        ard = 1'b1;
        start(2'h0, 1'b0, 1'b1, 24'h000002);
        waitFlag(n);
        tick(30);
        chk(oe, 1'b1);
        ie = 1'b0;
        tick(2);
        chk({flag, oe}, 24'h000002);
        ard = 1'b0;
        ie = 1'b1;
        start(2'h0, 1'b0, 1'b1, 24'h0000FF);
        for (int g = 0; g < 3; g++) begin
            gateEn = (g < 2);
            gateSel = g[0];
            safe = ~g[0];
            susp = (g == 2);
            tick(3);
            n = cnt;
            tick(40);
            chk(cnt, n[23:0]);
            safe = g[0];
            susp = 1'b0;
            tick(20);
            chk(cnt > n, 1'b1);
        end
        gateEn = 1'b0;
        start(2'h0, 1'b1, 1'b1, 24'h000002);
        tick(40);
        chk(flag, 1'b0);
        burst = 1'b1;
        waitFlag(n);
        burst = 1'b0;
        tick(40);
        chk({flag, oe}, 24'h000003);
        toFout = 1'b1;
        start(2'h0, 1'b0, 1'b1, 24'h000001);
        waitFlag(n);
        // Routed request passes one more register
        tick(1);
        chk({freq_out_pin, oe}, 24'h000000);
        summarize();
    end
    initial begin
        tick(80000);
        fails++;
        summarize();
    end
endmodule
`default_nettype wire
